// file: core/shdp_pkg.sv
package shdp_pkg;

  // Frame layout
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned DATA_BITS  = 24;
  localparam int unsigned STAT_BITS  = 8;
  localparam int unsigned ADDR_BITS  = 6;
  localparam int unsigned HDR_BITS   = FRAME_BITS - DATA_BITS;
  localparam int unsigned SEL_POS    = 31;
  localparam int unsigned RW_POS     = 24;
  localparam logic        RW_READ    = 1'h1;
  localparam logic        RW_WRITE   = 1'h0;
  localparam logic        SEL_REG    = 1'h0;
  localparam logic        SEL_RAM    = 1'h1;

  // Counter layout
  localparam int unsigned CNT_BITS   = 6;
  localparam logic [CNT_BITS-1:0] CNT_FULL  = 6'h20;
  localparam logic [CNT_BITS-1:0] CNT_HDR   = 6'h07;
  localparam logic [CNT_BITS-1:0] CNT_SAT   = 6'h3F;

  // Reset values
  localparam logic [FRAME_BITS-1:0] REPLY_RST = 32'h0000_0000;
  localparam logic [DATA_BITS-1:0]  DATA_ZERO = 24'h00_0000;

  // Timing in tenths of a system clock period, as printed
  localparam int unsigned TSD_MIN_TENTHS   = 25;
  localparam int unsigned TSD_MAX_TENTHS   = 35;
  localparam int unsigned TIS_MIN_TENTHS   = 25;
  localparam int unsigned TSI_MAX_TENTHS   = 45;
  localparam int unsigned TSETUP_TENTHS    = 30;
  localparam int unsigned CLK_PERIOD_NS    = 50;

  // Cycle counts: least times round up, longest times round down
  localparam int unsigned TSD_MIN_CYC = (TSD_MIN_TENTHS + 9) / 10;
  localparam int unsigned TSD_MAX_CYC = TSD_MAX_TENTHS / 10;
  localparam int unsigned TIS_MIN_CYC = (TIS_MIN_TENTHS + 9) / 10;
  localparam int unsigned TSI_MAX_CYC = TSI_MAX_TENTHS / 10;
  localparam int unsigned TSETUP_CYC  = (TSETUP_TENTHS + 9) / 10;

  // Host request word
  typedef struct packed {
    logic                 reg_ram_select;
    logic [ADDR_BITS-1:0] addr;
    logic                 rw;
    logic [DATA_BITS-1:0] data;
  } shdp_req_t;

  // Status byte returned at the head of every reply
  typedef struct packed {
    logic                 irq_status_n;
    logic [STAT_BITS-2:0] flags;
  } shdp_stat_t;

endpackage

// file: core/shdp_port.sv
// Overview of operation
// R01: Frames are 32 bits, MSB first
// R02: Reply shifts out while request shifts in
// R03: Request splits into select, address, rw, data
// R04: Rw one reads, zero writes
// R05: Reply holds status byte and 24 data bits
// R06: Select bit picks registers or RAM
// R07: Host zeroes data on reads, unused bits
// R08: Narrow or packed registers use data subsets
// R09: Select high three clocks before frame
// R10: Select low three clocks after last rise
// R11: Output bit follows clock fall within window
// R12: Interrupt status returns soon after deselect
// R13: Interrupt status holds after select falls
// R14: Serial clock low and high three clocks
// R15: Shift on rising clock, buffer at deselect
// R16: Deselected output carries interrupt status, always driven
// R17: Pins synchronised before edges are detected
`timescale 1ns/10ps
`default_nettype none

module shdp_port
(
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_host_sck,
  input  wire logic                           i_host_select_n,
  input  wire logic                           i_host_sdi,
  output logic                                o_host_serial_out,
  input  wire logic                           i_irq_status_n,
  input  wire logic [shdp_pkg::STAT_BITS-2:0] i_status,
  output logic                                o_rd_req,
  output var  shdp_pkg::shdp_req_t            o_rd_addr,
  input  wire logic [shdp_pkg::DATA_BITS-1:0] i_rd_data,
  output logic                                o_wr_valid,
  output var  shdp_pkg::shdp_req_t            o_wr_req,
  output logic                                o_frame_err
);
  import shdp_pkg::*;

  logic [FRAME_BITS-1:0] link_shift_q;
  logic [2:0]            pins_s;
  logic                  cs_s;
  logic                  sck_s;
  logic                  sdi_s;
  logic                  cs_p_q;
  logic                  sck_p_q;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  sck_rise;
  logic                  sck_fall;
  logic [CNT_BITS-1:0]   cnt_q;
  logic [HDR_BITS-1:0]   hdr_q;
  logic [HDR_BITS-1:0]   hdr_d;
  logic [FRAME_BITS-1:0] reply_q;
  logic                  sdo_q;
  logic                  sdo_half_q;
  shdp_req_t             rd_addr_d;
  shdp_req_t             link_word;

  // R15: link-side shift register on the host clock
  always_ff @(posedge i_host_sck)
  begin
    if (!i_host_select_n)
    begin
      link_shift_q <= {link_shift_q[FRAME_BITS-2:0], i_host_sdi};
    end
  end

  // R17: bring select, clock and data into the system domain
  shdp_sync
  #(
    .W       (3),
    .RST_VAL (3'h6)
  )
  u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_host_select_n, i_host_sck, i_host_sdi}),
    .o_sync    (pins_s)
  );

  assign cs_s  = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cs_p_q  <= 1'h1;
      sck_p_q <= 1'h1;
    end
    else
    begin
      cs_p_q  <= cs_s;
      sck_p_q <= sck_s;
    end
  end

  // R17: edges from synchronised levels only
  assign cs_fall  = cs_p_q & ~cs_s;
  assign cs_rise  = ~cs_p_q & cs_s;
  assign sck_rise = ~cs_s & ~sck_p_q & sck_s;
  assign sck_fall = ~cs_s & sck_p_q & ~sck_s;

  // R01: count rising clock edges of the frame
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
    end
    else if (cs_fall)
    begin
      cnt_q <= '0;
    end
    else if (sck_rise && (cnt_q != CNT_SAT))
    begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // R03: header bits arrive first, MSB first
  assign hdr_d = {hdr_q[HDR_BITS-2:0], sdi_s};

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      hdr_q <= '0;
    end
    else if (sck_rise && (cnt_q < CNT_FULL))
    begin
      hdr_q <= hdr_d;
    end
  end

  // R06: select and address go out with the read request
  always_comb
  begin
    rd_addr_d                = '0;
    rd_addr_d.reg_ram_select = hdr_d[HDR_BITS-1];
    rd_addr_d.addr           = hdr_d[HDR_BITS-2:1];
    rd_addr_d.rw             = hdr_d[0];
  end

  // R04: read request only when rw is one
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_rd_req  <= 1'h0;
      o_rd_addr <= '0;
    end
    else
    begin
      o_rd_req <= sck_rise && (cnt_q == CNT_HDR) && (hdr_d[0] == RW_READ);
      if (sck_rise && (cnt_q == CNT_HDR))
      begin
        o_rd_addr <= rd_addr_d;
      end
    end
  end

  // R05: status byte at frame start, read data after the header
  // R02: reply shifts one bit per falling clock
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      reply_q <= REPLY_RST;
    end
    else if (cs_fall)
    begin
      reply_q <= {i_irq_status_n, i_status, DATA_ZERO};
    end
    else if (o_rd_req)
    begin
      reply_q[FRAME_BITS-1:HDR_BITS] <= i_rd_data;
    end
    else if (sck_fall)
    begin
      reply_q <= {reply_q[FRAME_BITS-2:0], 1'h0};
    end
  end

  // R16: deselected output follows interrupt status
  // R12: status back soon after deselect
  // R13: status kept until first fall
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sdo_q <= 1'h1;
    end
    else if (cs_s)
    begin
      sdo_q <= i_irq_status_n;
    end
    else if (sck_fall)
    begin
      sdo_q <= reply_q[FRAME_BITS-1];
    end
  end

  // R11: half-period retime centres the bit window
  always_ff @(negedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sdo_half_q <= 1'h1;
    end
    else
    begin
      sdo_half_q <= sdo_q;
    end
  end

  assign o_host_serial_out = sdo_half_q;

  // R15: link word is still after the last rise, taken at deselect
  assign link_word = shdp_req_t'(link_shift_q);

  // R01: only whole 32-bit frames write; other lengths raise o_frame_err
  // R08: full data field goes out; narrow registers use subsets
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_wr_valid  <= 1'h0;
      o_wr_req    <= '0;
      o_frame_err <= 1'h0;
    end
    else
    begin
      o_wr_valid  <= cs_rise && (cnt_q == CNT_FULL) && (link_word.rw == RW_WRITE);
      o_frame_err <= cs_rise && (cnt_q != CNT_FULL);
      if (cs_rise && (cnt_q == CNT_FULL))
      begin
        o_wr_req <= link_word;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_idle_irq_out: assert property ( // R16
    cs_s |=> o_host_serial_out == $past(i_irq_status_n))
    else $error("output not interrupt status while deselected");

  a_irq_return: assert property ( // R12
    $rose(i_host_select_n) ##1 i_host_select_n[*2]
      |=> o_host_serial_out == $past(i_irq_status_n))
    else $error("interrupt status late after deselect");

  a_irq_hold_sel: assert property ( // R13
    $fell(i_host_select_n) |-> ##2 $stable(o_host_serial_out) ##1 $stable(o_host_serial_out))
    else $error("interrupt status not held after select");

  a_bit_after_fall: assert property ( // R11
    (!cs_s && $fell(sck_s)) |=> o_host_serial_out == $past(reply_q[FRAME_BITS-1]))
    else $error("output bit not presented after clock fall");

  a_read_only_rw: assert property ( // R04
    o_rd_req |-> o_rd_addr.rw == RW_READ && $past(cnt_q) == CNT_HDR)
    else $error("read request without rw set");

  a_reply_data: assert property ( // R05
    o_rd_req |=> reply_q[FRAME_BITS-1:HDR_BITS] == $past(i_rd_data))
    else $error("read data not placed in reply");

  a_status_load: assert property ( // R05
    cs_fall |=> reply_q == {$past(i_irq_status_n), $past(i_status), DATA_ZERO})
    else $error("status byte not loaded at frame start");

  a_write_whole: assert property ( // R01
    o_wr_valid |-> $past(cnt_q) == CNT_FULL && $past(cs_rise) && o_wr_req.rw == RW_WRITE)
    else $error("write from partial frame or read");

  a_frame_err: assert property ( // R01
    $past(cs_rise) && $past(cnt_q) != CNT_FULL |-> o_frame_err && !o_wr_valid)
    else $error("short frame not flagged");

  a_count_clear: assert property ( // R02
    cs_fall |=> cnt_q == '0 ##1 reply_q[FRAME_BITS-1] == $past(i_irq_status_n, 2))
    else $error("frame start not cleared");

  c_read_frame: cover property (o_rd_req ##[1:1000] cs_rise);
  c_write_frame: cover property (o_wr_valid && o_wr_req.reg_ram_select == SEL_RAM);
  c_reg_write: cover property (o_wr_valid && o_wr_req.reg_ram_select == SEL_REG);
  c_short_frame: cover property (o_frame_err);

endmodule

`default_nettype wire

// file: core/shdp_sync.sv
`timescale 1ns/10ps
`default_nettype none

module shdp_sync
#(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // Two stages; the first is read by the second only
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: dv/serial_host_datagram_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module serial_host_datagram_port_tb_top;
  import shdp_pkg::*;
  logic        clk, lclk, rst_n, irq_n, rd_req, wr_valid, ferr, so, sck, sel_n, sdi;
  logic [6:0]  stat;
  logic [23:0] rdd;
  logic [31:0] rx;
  shdp_req_t   rd_addr, wr_req, wr_cap;
  int          failures, checked, n_wr, n_rd, n_err;

  shdp_port dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_host_sck(sck),
    .i_host_select_n(sel_n), .i_host_sdi(sdi), .o_host_serial_out(so),
    .i_irq_status_n(irq_n), .i_status(stat), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .i_rd_data(rdd), .o_wr_valid(wr_valid), .o_wr_req(wr_req), .o_frame_err(ferr));

  shdp_host_bfm host_u (.i_lclk(lclk), .i_so(so), .o_sck(sck), .o_sel_n(sel_n),
    .o_sdi(sdi));

  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    lclk = 0;
    #3;
    forever #6 lclk = ~lclk;
  end

  // Pulse counters seen at the request and frame error ports
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1)
    begin
      n_wr++;
      wr_cap = wr_req;
    end
    if (rd_req === 1'b1)
      n_rd++;
    if (ferr === 1'b1)
      n_err++;
  end

  task automatic run(input logic [31:0] tx, input int nb);
    n_wr  = 0;
    n_rd  = 0;
    n_err = 0;
    host_u.xfer(tx, nb, rx);
    repeat (6) @(posedge clk);
  endtask

  task automatic t_idle();
    @(posedge clk) irq_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("idle low", 1'b0, so)
    @(posedge clk) irq_n <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("idle high", 1'b1, so)
  endtask

  task automatic t_write();
    run(32'h6600_0123, 32);
    `CHK("wr reply", 32'h9500_0000, rx)
    `CHK("wr count", 1, n_wr)
    `CHK("wr no err", 0, n_err)
    `CHK("wr word", 32'h6600_0123, wr_cap)
    `CHK("so back", 1'b1, so)
    run(32'hFE00_0861, 32);
    `CHK("ram sel", SEL_RAM, wr_cap.reg_ram_select)
    `CHK("ram addr", 6'h3F, wr_cap.addr)
  endtask

  task automatic t_read();
    @(posedge clk) rdd <= 24'hA5_5A3C;
    run(32'h6700_0000, 32);
    `CHK("rd reply", 32'h95A5_5A3C, rx)
    `CHK("rd count", 1, n_rd)
    `CHK("rd no wr", 0, n_wr)
    `CHK("rd addr", 6'h33, rd_addr.addr)
    `CHK("rd sel", SEL_REG, rd_addr.reg_ram_select)
    `CHK("rd rw", RW_READ, rd_addr.rw)
  endtask

  task automatic t_short();
    run(32'h6600_0001, 31);
    `CHK("short err", 1, n_err)
    `CHK("short wr", 0, n_wr)
  endtask

  task automatic t_irq();
    @(posedge clk) irq_n <= 1'b0;
    stat <= 7'h2A;
    run(32'h0200_0000, 32);
    `CHK("irq bit", 32'h2A00_0000, rx)
    `CHK("irq wr", 1, n_wr)
    `CHK("irq after", 1'b0, so)
    @(posedge clk) irq_n <= 1'b1;
    stat <= 7'h15;
  endtask

  task automatic summarize();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    irq_n = 1'b1;
    stat  = 7'h15;
    rdd   = 24'h00_0000;
    repeat (3) @(posedge clk);
    `CHK("rst out", 1'b1, so)
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_idle();
    t_write();
    t_read();
    t_short();
    t_irq();
    summarize();
  end

  initial
  begin
    #500_000;
    failures++;
    summarize();
  end
endmodule

`default_nettype wire

// file: dv/shdp_host_bfm.sv
`timescale 1ns/10ps
`default_nettype none

module shdp_host_bfm
(
  input  wire logic i_lclk,
  input  wire logic i_so,
  output logic      o_sck,
  output logic      o_sel_n,
  output logic      o_sdi
);
  initial
  begin
    o_sck   = 1'b1;
    o_sel_n = 1'b1;
    o_sdi   = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_lclk);
  endtask

  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    wt(20);
    o_sel_n <= 1'b0;
    wt(20);
    for (int i = 31; i > 31 - nb; i--)
    begin
      o_sck <= 1'b0;
      o_sdi <= tx[i];
      wt(20);
      o_sck <= 1'b1;
      rx[i] = i_so;
      wt(20);
    end
    wt(20);
    o_sel_n <= 1'b1;
    o_sdi   <= ~o_sdi;
    wt(20);
  endtask
endmodule

`default_nettype wire
